// *** logic/twi_register_slave.sv ***
// Two-wire slave port giving an external master access to 8-bit registers.
// Assumes the register file answers reg_rdata_i combinationally from reg_addr_o.
`timescale 1ns/10ps
`default_nettype none

module twi_register_slave (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_select_pins_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_we_o,
  input wire logic [7:0] reg_rdata_i
);

  twi_slave_pkg::twi_state_t state_q;
  logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
  logic sel_meta_q, sel_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] wdata_q;
  logic [7:0] tx_q;
  logic we_q, rw_q, first_q, oe_q;
  logic byte_done, addr_match;

  // ==========================================================
  // Line sampling
  twi_line_sampler u_lines (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_o(scl_s),
    .sda_o(sda_s),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start_ev),
    .stop_o(stop_ev)
  );

  // Address select pin is a strap-like pin, synchronised all the same
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_meta_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      sel_meta_q <= address_select_pins_i;
      sel_q <= sel_meta_q;
    end
  end

  assign byte_done = scl_fall && (cnt_q == twi_slave_pkg::BYTE_BITS);
  assign addr_match = (shift_q[7:1] == {twi_slave_pkg::OWN_ADDR_HIGH, sel_q});

  // ==========================================================
  // Bit counter and receive shifter
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
    end else if (start_ev || stop_ev) begin
      cnt_q <= 4'h0;
    end else if (scl_rise && (state_q == twi_slave_pkg::ST_ADDR ||
                 state_q == twi_slave_pkg::ST_RX)) begin
      shift_q <= {shift_q[6:0], sda_s};
      cnt_q <= cnt_q + 4'h1;
    end else if (scl_rise && state_q == twi_slave_pkg::ST_TX) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (scl_fall && (state_q == twi_slave_pkg::ST_ACK_ADDR ||
                 state_q == twi_slave_pkg::ST_ACK_RX ||
                 state_q == twi_slave_pkg::ST_MACK)) begin
      cnt_q <= 4'h0;
    end
  end

  // ==========================================================
  // Protocol sequencer and SDA drive; oe only ever pulls low
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= twi_slave_pkg::ST_IDLE;
      oe_q <= 1'b0;
      rw_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (start_ev) begin
      // A start with or without a stop before it restarts addressing
      state_q <= twi_slave_pkg::ST_ADDR;
      oe_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= twi_slave_pkg::ST_IDLE;
      oe_q <= 1'b0;
    end else begin
      case (state_q)
        twi_slave_pkg::ST_ADDR: begin
          if (byte_done) begin
            rw_q <= shift_q[0];
            if (addr_match) begin
              oe_q <= 1'b1;
              state_q <= twi_slave_pkg::ST_ACK_ADDR;
            end else begin
              state_q <= twi_slave_pkg::ST_IGNORE;
            end
          end
        end
        twi_slave_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_q) begin
              // Read starts at the stored base, first bit driven right away
              tx_q <= reg_rdata_i;
              oe_q <= ~reg_rdata_i[7];
              state_q <= twi_slave_pkg::ST_TX;
            end else begin
              oe_q <= 1'b0;
              state_q <= twi_slave_pkg::ST_RX;
            end
          end
        end
        twi_slave_pkg::ST_RX: begin
          if (byte_done) begin
            oe_q <= 1'b1;
            state_q <= twi_slave_pkg::ST_ACK_RX;
          end
        end
        twi_slave_pkg::ST_ACK_RX: begin
          if (scl_fall) begin
            oe_q <= 1'b0;
            state_q <= twi_slave_pkg::ST_RX;
          end
        end
        twi_slave_pkg::ST_TX: begin
          if (byte_done) begin
            oe_q <= 1'b0;
            state_q <= twi_slave_pkg::ST_MACK;
          end else if (scl_fall) begin
            oe_q <= ~tx_q[3'h7 - cnt_q[2:0]];
          end
        end
        twi_slave_pkg::ST_MACK: begin
          if (scl_rise && sda_s) begin
            state_q <= twi_slave_pkg::ST_IGNORE;
          end else if (scl_fall) begin
            tx_q <= reg_rdata_i;
            oe_q <= ~reg_rdata_i[7];
            state_q <= twi_slave_pkg::ST_TX;
          end
        end
        twi_slave_pkg::ST_IGNORE: begin
          oe_q <= 1'b0;
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Base pointer, write strobe and write data
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_q <= twi_slave_pkg::PTR_RESET;
      first_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      we_q <= 1'b0;
      if (start_ev) begin
        first_q <= 1'b1;
      end else if (we_q) begin
        ptr_q <= ptr_q + twi_slave_pkg::PTR_STEP;
      end else if (state_q == twi_slave_pkg::ST_RX && byte_done) begin
        if (first_q) begin
          ptr_q <= shift_q;
          first_q <= 1'b0;
        end else begin
          wdata_q <= shift_q;
          we_q <= 1'b1;
        end
      end else if (state_q == twi_slave_pkg::ST_TX && byte_done) begin
        ptr_q <= ptr_q + twi_slave_pkg::PTR_STEP;
      end
    end
  end

  // Open drain: the data level is always low, only the enable moves
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  assign sda_oe_o = oe_q;
  assign reg_addr_o = ptr_q;
  assign reg_wdata_o = wdata_q;
  assign reg_we_o = we_q;

  // ==========================================================
  // Assertions
  property p_ack_on_match;
    @(posedge clock_i) disable iff (!rst_n_i)
    (state_q == twi_slave_pkg::ST_ADDR && byte_done && addr_match && !start_ev && !stop_ev)
      |=> oe_q && state_q == twi_slave_pkg::ST_ACK_ADDR;
  endproperty
  a_ack_on_match: assert property (p_ack_on_match) else $error("no ack on match");

  property p_ignore_mismatch;
    @(posedge clock_i) disable iff (!rst_n_i)
    (state_q == twi_slave_pkg::ST_ADDR && byte_done && !addr_match && !start_ev && !stop_ev)
      |=> !oe_q && state_q == twi_slave_pkg::ST_IGNORE && $stable(ptr_q);
  endproperty
  a_ignore_mismatch: assert property (p_ignore_mismatch) else $error("mismatch acked");

  property p_drive_scl_low;
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(oe_q) |-> !scl_s;
  endproperty
  a_drive_scl_low: assert property (p_drive_scl_low) else $error("sda pulled while scl high");

  property p_restart;
    @(posedge clock_i) disable iff (!rst_n_i)
    start_ev |=> state_q == twi_slave_pkg::ST_ADDR && !oe_q && cnt_q == 4'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("start not taken");

  property p_stop_idle;
    @(posedge clock_i) disable iff (!rst_n_i)
    stop_ev |=> state_q == twi_slave_pkg::ST_IDLE && !oe_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

  property p_base_stored;
    @(posedge clock_i) disable iff (!rst_n_i)
    (state_q == twi_slave_pkg::ST_RX && byte_done && first_q && !start_ev && !stop_ev)
      |=> ptr_q == $past(shift_q) && !we_q;
  endproperty
  a_base_stored: assert property (p_base_stored) else $error("base not stored");

  property p_write_incr;
    @(posedge clock_i) disable iff (!rst_n_i)
    (we_q && !start_ev) |=> ptr_q == $past(ptr_q) + 8'h01;
  endproperty
  a_write_incr: assert property (p_write_incr) else $error("write address not advanced");

  property p_nack_release;
    @(posedge clock_i) disable iff (!rst_n_i)
    (state_q == twi_slave_pkg::ST_MACK && scl_rise && sda_s && !start_ev && !stop_ev)
      |=> state_q == twi_slave_pkg::ST_IGNORE ##1 !oe_q;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("nack not honoured");

  property p_msb_first;
    @(posedge clock_i) disable iff (!rst_n_i)
    (state_q == twi_slave_pkg::ST_ACK_ADDR && scl_fall && rw_q && !start_ev && !stop_ev)
      |=> oe_q == !$past(reg_rdata_i[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first read bit not msb");

  c_write: cover property (@(posedge clock_i) disable iff (!rst_n_i) we_q);
  c_read_byte: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    state_q == twi_slave_pkg::ST_MACK && scl_fall);
  c_restart: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    start_ev && state_q != twi_slave_pkg::ST_IDLE);
  c_nack: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    state_q == twi_slave_pkg::ST_MACK && scl_rise && sda_s);

endmodule

`default_nettype wire

// *** pkg/twi_slave_pkg.sv ***
// Constants and state type for the two-wire register slave port.
// Assumes a single 200 MHz core clock and 8-bit device registers.
package twi_slave_pkg;

  // ==========================================================
  // Addressing
  localparam logic [5:0] OWN_ADDR_HIGH = 6'h26; // Fixed upper address bits 100110
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam int CLOCK_MHZ = 200;

  // ==========================================================
  // Protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_RX,
    ST_ACK_RX,
    ST_TX,
    ST_MACK,
    ST_IGNORE
  } twi_state_t;

endpackage

// *** logic/twi_line_sampler.sv ***
// Two-flop synchroniser and event finder for the bus lines.
// Assumes SCL and SDA are asynchronous to clock_i and far slower than it.
`timescale 1ns/10ps
`default_nettype none

module twi_line_sampler (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o
);

  logic scl_meta_q, scl_sync_q, scl_last_q;
  logic sda_meta_q, sda_sync_q, sda_last_q;

  // ==========================================================
  // Synchronisers; idle bus reads high
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      scl_last_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      sda_last_q <= 1'b1;
    end else begin
      scl_meta_q <= scl_i;
      scl_sync_q <= scl_meta_q;
      scl_last_q <= scl_sync_q;
      sda_meta_q <= sda_i;
      sda_sync_q <= sda_meta_q;
      sda_last_q <= sda_sync_q;
    end
  end

  // Edge and condition detection on the settled copies only
  assign scl_o = scl_sync_q;
  assign sda_o = sda_sync_q;
  assign scl_rise_o = scl_sync_q & ~scl_last_q;
  assign scl_fall_o = ~scl_sync_q & scl_last_q;
  // SDA moving while SCL stays high is a condition, never data
  assign start_o = scl_sync_q & scl_last_q & sda_last_q & ~sda_sync_q;
  assign stop_o = scl_sync_q & scl_last_q & ~sda_last_q & sda_sync_q;

endmodule

`default_nettype wire

// *** tb/twi_master_model.sv ***
// Bus master model for the two-wire slave port: drives SCL, pulls SDA low.
// Assumes SDA is resolved outside with a pull-up; SCL stands high between frames.
`timescale 1ns/10ps
`default_nettype none

module twi_master_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  localparam real Q = 31.25; // Quarter of the 125 ns bit period

  // ====================
  // Line primitives
  // Only ever pulls low, so a released line reads back through the pull-up
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Start or repeated start from a released SDA
  task automatic start_cond();
    sda_pull_o = 1'b0;
    #Q scl_o = 1'b1;
    #(2*Q) sda_pull_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  // Stop leaves both lines at rest
  task automatic stop_cond();
    sda_pull_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_pull_o = 1'b0;
    #(2*Q);
  endtask

  // Data changes only in the low phase of SCL
  task automatic bit_out(input logic b);
    sda_pull_o = ~b;
    #Q scl_o = 1'b1;
    #(2*Q) scl_o = 1'b0;
    #Q;
  endtask

  task automatic bit_in(output logic b);
    sda_pull_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q b = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  // ====================
  // Byte transfers, MSB first
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask

  task automatic byte_rd(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(nack);
  endtask
endmodule
`default_nettype wire

// *** tb/two_wire_register_slave_port_tb.sv ***
// Self-checking bench for the two-wire register slave port.
// Assumes the master model in twi_master_model.sv and a bench register file.
`timescale 1ns/10ps
`default_nettype none

module two_wire_register_slave_port_tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sel_pin = 1'b0;
  logic scl, m_pull, sda_wire, sda_oe, sda_lvl, reg_we;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] regs [256];
  int n_errors = 0;
  int n_compared = 0;
  int n_writes = 0;

  // ====================
  // Wiring
  always #2.5 clock_i = ~clock_i;
  assign sda_wire = (m_pull | sda_oe) ? 1'b0 : 1'b1;
  assign reg_rdata = regs[reg_addr];

  twi_master_model m (.sda_i(sda_wire), .scl_o(scl), .sda_pull_o(m_pull));

  twi_register_slave uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_wire),
    .sda_o(sda_lvl), .sda_oe_o(sda_oe), .address_select_pins_i(sel_pin),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_we_o(reg_we),
    .reg_rdata_i(reg_rdata)
  );

  // Register file takes each write strobe
  always @(posedge clock_i) begin
    if (reg_we === 1'b1) begin
      regs[reg_addr] <= reg_wdata;
      n_writes <= n_writes + 1;
    end
  end

  // Device may only move SDA while SCL is low, and may only ever pull it low
  always @(sda_oe) begin
    if (rst_n_i === 1'b1 && scl === 1'b1) begin
      $display("[FAIL] sda_oe edge in SCL high: expected 0 seen 1");
      n_errors++;
    end
    if (rst_n_i === 1'b1 && sda_oe === 1'b1 && sda_lvl !== 1'b0) begin
      $display("[FAIL] sda_o while driving: expected 0 seen %b", sda_lvl);
      n_errors++;
    end
  end

  // ====================
  // Checking and closing
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s: expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Write three registers across the pointer wrap
  // Data keeps bit 7 clear, so a byte driven after a NACK would pull SDA
  task automatic t_write(input logic a0);
    logic ack;
    int w0;
    @(posedge clock_i) #1 sel_pin = a0;
    repeat (4) @(posedge clock_i);
    w0 = n_writes;
    m.start_cond();
    m.byte_wr({twi_slave_pkg::OWN_ADDR_HIGH, a0, 1'b0}, ack);
    chk("address ack", 8'h01, {7'h00, ack});
    m.byte_wr(8'hfe, ack);
    chk("base ack", 8'h01, {7'h00, ack});
    for (int i = 0; i < 3; i++) begin
      m.byte_wr(8'h21 + 8'(i * 17), ack);
      chk("data ack", 8'h01, {7'h00, ack});
    end
    m.stop_cond();
    chk("write count", 8'h03, 8'(n_writes - w0));
    for (int i = 0; i < 3; i++) chk("written", 8'h21 + 8'(i * 17), regs[8'hfe + 8'(i)]);
  endtask

  // Set base, repeated start, read three with NACK on the last
  task automatic t_read();
    logic ack;
    logic [7:0] d;
    logic [7:0] exp [3];
    exp = '{8'hfd ^ 8'h5a, 8'h21, 8'h32};
    m.start_cond();
    m.byte_wr({twi_slave_pkg::OWN_ADDR_HIGH, sel_pin, 1'b0}, ack);
    m.byte_wr(8'hfd, ack);
    m.start_cond();
    m.byte_wr({twi_slave_pkg::OWN_ADDR_HIGH, sel_pin, 1'b1}, ack);
    chk("read address ack", 8'h01, {7'h00, ack});
    for (int i = 0; i < 3; i++) begin
      m.byte_rd(i == 2, d);
      chk("read data", exp[i], d);
    end
    #50;
    chk("released after nack", 8'h00, {7'h00, sda_oe});
    m.stop_cond();
  endtask

  // Foreign addresses are ignored; pointer and registers untouched
  task automatic t_ignore();
    logic ack;
    logic [7:0] p0, d;
    int w0;
    p0 = reg_addr;
    w0 = n_writes;
    m.start_cond();
    m.byte_wr({twi_slave_pkg::OWN_ADDR_HIGH, ~sel_pin, 1'b0}, ack);
    chk("foreign a0 ack", 8'h00, {7'h00, ack});
    m.byte_wr(8'h10, ack);
    m.byte_wr(8'h55, ack);
    m.start_cond();
    m.byte_wr(8'h30, ack);
    chk("foreign high ack", 8'h00, {7'h00, ack});
    m.byte_wr(8'h20, ack);
    m.stop_cond();
    chk("pointer kept", p0, reg_addr);
    chk("no writes", 8'h00, 8'(n_writes - w0));
    m.start_cond();
    m.byte_wr({twi_slave_pkg::OWN_ADDR_HIGH, sel_pin, 1'b1}, ack);
    m.byte_rd(1'b1, d);
    chk("read from kept pointer", 8'h43, d);
    m.stop_cond();
  endtask

  // ====================
  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
    repeat (5) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    t_write(1'b0);
    t_read();
    t_ignore();
    t_write(1'b1);
    t_read();
    stop_test();
  end

  // Watchdog well beyond the expected 35 us of traffic
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
